// >>> dmx_pkg.sv
// Purpose: shared constants and types for the data-move execution block
// Assumes: 16-bit instruction words, 12-bit data addresses, 8-bit data
// Notes:   quarter phase codes run 0..3 inside each instruction cycle
package dmx_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 8;

  // ----------------------------------------------------------------
  // quarter phases
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ   = 2'h1;
  localparam logic [1:0] PH_PROC   = 2'h2;
  localparam logic [1:0] PH_WRITE  = 2'h3;

  // ----------------------------------------------------------------
  // opcode prefixes
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_COPY_SRC   = 4'hC;  // first word, source address
  localparam logic [3:0] OPC_COPY_DST   = 4'hF;  // second word, destination address
  localparam logic [7:0] OPC_LOAD_BANK  = 8'h01;
  localparam logic [7:0] OPC_LOAD_WORK  = 8'h0E;
  localparam logic [3:0] BANK_UPPER_VAL = 4'h0;

  // ----------------------------------------------------------------
  // reset values and default mapping of the working register
  // ----------------------------------------------------------------
  localparam logic [7:0]  WORK_RST     = 8'h00;
  localparam logic [7:0]  BANK_RST     = 8'h00;
  localparam logic [11:0] WORK_ADDR_DF = 12'hF80;

  // sequencing states
  typedef enum logic [1:0] {
    DMX_IDLE  = 2'b00,
    DMX_COPY1 = 2'b01,
    DMX_COPY2 = 2'b10
  } dmx_state_type;

  // pending single-word operation
  typedef enum logic [1:0] {
    DMX_OP_NONE = 2'b00,
    DMX_OP_BANK = 2'b01,
    DMX_OP_WORK = 2'b10
  } dmx_op_type;

endpackage

// >>> dmx_phase_if.sv
// Purpose: carries the quarter phase from the sequencer to the executor
// Assumes: one phase step per core clock
// Notes:   two-bit phase code, see dmx_pkg
`timescale 1ns/1ps
interface dmx_phase_if;
  logic [1:0] phase;

  // phase generator side
  modport gen (output phase);
  // phase consumer side
  modport use_ph (input phase);
endinterface

// >>> dmx_qphase.sv
// Purpose: quarter phase counter dividing each instruction cycle in four
// Assumes: single clock, asynchronous active-low reset
// Notes:   phase is a flop output, decode phase first after reset
`timescale 1ns/1ps
module dmx_qphase
  import dmx_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // phase out
  dmx_phase_if.gen  ph
);

  typedef struct packed {
    logic [1:0] cnt;
  } dmx_qp_type;

  dmx_qp_type st_reg;
  dmx_qp_type st_next;

  // next phase, wraps after the write quarter
  always_comb
  begin
    st_next     = st_reg;
    st_next.cnt = st_reg.cnt + 2'h1;
  end

  // state register
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_reg <= '{cnt: PH_DECODE};
    else
      st_reg <= st_next;
  end

  assign ph.phase = st_reg.cnt;

endmodule

// >>> dmx_exec.sv
// Purpose: executes the file-to-file copy, bank load and literal load
// Assumes: program memory holds instr_i stable across the edge that ends each decode quarter;
//          data memory answers a read combinationally while dm_rd_o is high
// Notes:   other opcodes are ignored here and handled elsewhere in the core
`timescale 1ns/1ps

module dmx_exec
  import dmx_pkg::*;
#(
  parameter logic [11:0] WORK_ADDR = WORK_ADDR_DF
)
(
  // clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        nrst_i,
  // program memory
  input  wire logic [dmx_pkg::INSTR_W-1:0] instr_i,
  output logic                             fetch_o,
  // data memory
  output logic [dmx_pkg::ADDR_W-1:0]       dm_addr_o,
  output logic                             dm_rd_o,
  input  wire logic [dmx_pkg::DATA_W-1:0]  dm_rdata_i,
  output logic                             dm_wr_o,
  output logic [dmx_pkg::DATA_W-1:0]       dm_wdata_o,
  // core registers
  output logic [dmx_pkg::DATA_W-1:0]       work_reg_o,
  output logic [dmx_pkg::DATA_W-1:0]       bank_select_reg_o
);

  // ----------------------------------------------------------------
  // quarter phase sequencer
  // ----------------------------------------------------------------
  dmx_phase_if ph_if ();

  dmx_qphase u_qphase (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ph         (ph_if.gen)
  );

  logic [1:0] phase;
  assign phase = ph_if.phase;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dmx_state_type state;
    dmx_op_type    op;
    logic [7:0]    lit;
    logic [11:0]   src;
    logic [11:0]   dst;
    logic          dst_ok;
    logic [7:0]    data;
    logic [7:0]    work;
    logic [7:0]    bank;
    logic [11:0]   addr;
    logic [7:0]    wdata;
    logic          rd;
    logic          wr;
  } dmx_exec_type;

  localparam dmx_exec_type EXEC_RST = '{
    state: DMX_IDLE, op: DMX_OP_NONE, lit: 8'h00, src: 12'h000, dst: 12'h000,
    dst_ok: 1'b0, data: 8'h00, work: WORK_RST, bank: BANK_RST, addr: 12'h000,
    wdata: 8'h00, rd: 1'b0, wr: 1'b0};

  dmx_exec_type st_reg;
  dmx_exec_type st_next;

  // next state, one step per quarter phase
  always_comb
  begin
    st_next    = st_reg;
    st_next.rd = 1'b0;
    st_next.wr = 1'b0;
    case (phase)
      PH_DECODE:
      begin
        st_next.op = DMX_OP_NONE;
        case (st_reg.state)
          DMX_IDLE:
          begin
            if (instr_i[15:12] == OPC_COPY_SRC)
            begin
              st_next.state = DMX_COPY1;
              st_next.src   = instr_i[11:0];
              if (instr_i[11:0] != WORK_ADDR)
              begin
                st_next.rd   = 1'b1;  // read issued for the read quarter
                st_next.addr = instr_i[11:0];
              end
            end
            else if (instr_i[15:8] == OPC_LOAD_BANK)
            begin
              st_next.op  = DMX_OP_BANK;
              st_next.lit = instr_i[7:0];
            end
            else if (instr_i[15:8] == OPC_LOAD_WORK)
            begin
              st_next.op  = DMX_OP_WORK;
              st_next.lit = instr_i[7:0];
            end
          end
          DMX_COPY2:
          begin
            st_next.dst    = instr_i[11:0];
            st_next.dst_ok = (instr_i[15:12] == OPC_COPY_DST);
          end
          default:
          begin
            st_next.state = DMX_IDLE;
          end
        endcase
      end
      PH_READ:
      begin
        if (st_reg.state == DMX_COPY1)
        begin
          // working register as source is taken internally
          st_next.data = (st_reg.src == WORK_ADDR) ? st_reg.work : dm_rdata_i;
        end
      end
      PH_PROC:
      begin
        // destination write lands in the last quarter, no dummy read
        if (st_reg.state == DMX_COPY2 && st_reg.dst_ok && st_reg.dst != WORK_ADDR)
        begin
          st_next.wr    = 1'b1;
          st_next.addr  = st_reg.dst;
          st_next.wdata = st_reg.data;
        end
      end
      PH_WRITE:
      begin
        case (st_reg.state)
          DMX_COPY1:
          begin
            st_next.state = DMX_COPY2;
          end
          DMX_COPY2:
          begin
            st_next.state = DMX_IDLE;
            // the stream never names counter or stack bytes here
            if (st_reg.dst_ok && st_reg.dst == WORK_ADDR)
              st_next.work = st_reg.data;
          end
          default:
          begin
            if (st_reg.op == DMX_OP_BANK)
              st_next.bank = {BANK_UPPER_VAL, st_reg.lit[3:0]};
            else if (st_reg.op == DMX_OP_WORK)
              st_next.work = st_reg.lit;
          end
        endcase
      end
      default:
      begin
        st_next = st_reg;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_reg <= EXEC_RST;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fetch_o           = (phase == PH_DECODE);  // word taken in decode quarter
  assign dm_addr_o         = st_reg.addr;
  assign dm_rd_o           = st_reg.rd;
  assign dm_wr_o           = st_reg.wr;
  assign dm_wdata_o        = st_reg.wdata;
  assign work_reg_o        = st_reg.work;
  assign bank_select_reg_o = st_reg.bank;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] seen_rd_data;

  // last byte returned by data memory
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      seen_rd_data <= 8'h00;
    else if (dm_rd_o)
      seen_rd_data <= dm_rdata_i;
  end

  AST_COPY_SAME_BYTE: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (dm_wr_o && st_reg.src != WORK_ADDR) |-> dm_wdata_o == seen_rd_data)
    else $error("copied byte differs from byte read");

  AST_FULL_SRC_ADDR: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    dm_rd_o |-> (dm_addr_o == $past(instr_i[11:0]) && phase == PH_READ))
    else $error("source address not the full 12-bit field");

  AST_COPY_TO_WORK: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (phase == PH_WRITE && st_reg.state == DMX_COPY2 && st_reg.dst_ok && st_reg.dst == WORK_ADDR)
      |=> (work_reg_o == $past(st_reg.data) && !dm_wr_o))
    else $error("copy into working register failed");

  AST_BANK_LOAD: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (phase == PH_DECODE && st_reg.state == DMX_IDLE && instr_i[15:8] == OPC_LOAD_BANK)
      |-> ##4 (bank_select_reg_o == {4'h0, $past(instr_i[3:0], 4)}))
    else $error("bank load value wrong");

  AST_WORK_LOAD: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (phase == PH_DECODE && st_reg.state == DMX_IDLE && instr_i[15:8] == OPC_LOAD_WORK)
      |-> ##4 (work_reg_o == $past(instr_i[7:0], 4)))
    else $error("literal load value wrong");

  AST_WRITE_LAST_QUARTER: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    dm_wr_o |-> (phase == PH_WRITE && !dm_rd_o && $past(st_reg.state) == DMX_COPY2))
    else $error("copy write outside last quarter of second cycle");

endmodule

// >>> dmx_pmem_model.sv
// Purpose: program memory model that feeds instruction words to the core
// Assumes: the bench queues words before their decode quarter comes round
// Notes:   outside decode quarters the bus shows a pattern that changes each cycle
`timescale 1ns/1ps
module dmx_pmem_model
  import dmx_pkg::*;
(
  // clock, reset and fetch strobe
  input  wire logic                        core_clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        fetch_i,
  // instruction word
  output logic [dmx_pkg::INSTR_W-1:0]      instr_o
);
  logic [INSTR_W-1:0] words [$];

  // queue one word for a later decode quarter
  task automatic push(input logic [INSTR_W-1:0] w);
    words.push_back(w);
  endtask

  initial instr_o = 16'h0000;

  // word held through the decode edge, filler toggles otherwise (empty queue gives an ignored opcode)
  always @(negedge core_clk_i)
  begin
    if (nrst_i && fetch_i)
      instr_o <= (words.size() > 0) ? words.pop_front() : 16'h0000;
    else
      instr_o <= ~instr_o;
  end
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the data-move execution block
// Assumes: default working register address, data memory modelled here
// Notes:   instr_i and nrst_i change at the falling edge, dm_rdata_i just after the rising edge
`timescale 1ns/1ps
module tb_top;
  import dmx_pkg::*;
  logic               core_clk_i, nrst_i, fetch_o, dm_rd_o, dm_wr_o, junk;
  logic [INSTR_W-1:0] instr_i;
  logic [ADDR_W-1:0]  dm_addr_o;
  logic [DATA_W-1:0]  dm_rdata_i, dm_wdata_o, work_reg_o, bank_select_reg_o;
  logic [DATA_W-1:0]  mem [0:4095];
  int                 error_cnt, num_checks, rd_cnt, wr_cnt, tick, rd_tick, gap;

  dmx_exec u_dmx_exec (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .instr_i(instr_i), .fetch_o(fetch_o),
    .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_rdata_i(dm_rdata_i), .dm_wr_o(dm_wr_o),
    .dm_wdata_o(dm_wdata_o), .work_reg_o(work_reg_o), .bank_select_reg_o(bank_select_reg_o));
  dmx_pmem_model u_dmx_pmem_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .fetch_i(fetch_o),
    .instr_o(instr_i));

  // clock, 50 ns period
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // data memory: combinational read, junk when not selected, write on strobe
  assign dm_rdata_i = dm_rd_o ? mem[dm_addr_o] : ({8{junk}} ^ 8'h5A);
  always @(posedge core_clk_i)
  begin
    tick++;
    junk <= ~junk;
    if (dm_rd_o === 1'b1)
    begin
      rd_cnt++;
      rd_tick = tick;
    end
    if (dm_wr_o === 1'b1)
    begin
      wr_cnt++;
      gap = tick - rd_tick;
      mem[dm_addr_o] <= dm_wdata_o;
    end
  end

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // queue one or two words and let them execute
  task automatic run(input logic [15:0] w1, input logic [15:0] w2);
    rd_cnt = 0;
    wr_cnt = 0;
    // queue at a rising edge so the model's falling-edge pop never races the push
    @(posedge core_clk_i);
    u_dmx_pmem_model.push(w1);
    if (w2 !== 16'h0000)
      u_dmx_pmem_model.push(w2);
    repeat (16) @(negedge core_clk_i);
  endtask

  // bank load keeps the upper nibble clear for every literal
  task automatic t_bank();
    logic [7:0] ks [4] = '{8'hFF, 8'hA5, 8'h0F, 8'h00};
    foreach (ks[i])
    begin
      run({8'h01, ks[i]}, 16'h0000);
      check(bank_select_reg_o, {4'h0, ks[i][3:0]});
    end
    $display("test bank load done");
  endtask

  // literal load, including back-to-back words
  task automatic t_work();
    logic [7:0] ks [3] = '{8'hFF, 8'h5A, 8'h00};
    foreach (ks[i])
    begin
      run({8'h0E, ks[i]}, 16'h0000);
      check(work_reg_o, ks[i]);
    end
    run({8'h01, 8'h37}, {8'h0E, 8'h22});
    check(work_reg_o, 8'h22);
    check(bank_select_reg_o, 8'h07);
    $display("test literal load done");
  endtask

  // copy one byte; source or destination may be the working register
  task automatic t_copy(input logic [11:0] s, input logic [11:0] d, input logic [7:0] v);
    if (s != WORK_ADDR_DF)
      mem[s] = v;
    else
      run({8'h0E, v}, 16'h0000);
    if (d != WORK_ADDR_DF)
      mem[d] = ~v;
    run({4'hC, s}, {4'hF, d});
    check((d == WORK_ADDR_DF) ? work_reg_o : mem[d], v);
    check(16'(rd_cnt), {15'h0000, s != WORK_ADDR_DF});
    check(16'(wr_cnt), {15'h0000, d != WORK_ADDR_DF});
    if (s != WORK_ADDR_DF && d != WORK_ADDR_DF)
    begin
      check(mem[s], v);
      check(16'(gap), 16'h0006);
    end
    $display("test copy done");
  endtask

  // second word without the destination prefix: source read, nothing written
  task automatic t_bad_dst();
    mem[12'h123] = 8'h99;
    run({4'hC, 12'h040}, 16'h5123);
    check(16'(rd_cnt), 16'h0001);
    check(16'(wr_cnt), 16'h0000);
    check(mem[12'h123], 8'h99);
    $display("test bad destination done");
  endtask

  // reset clears both registers
  task automatic t_reset();
    nrst_i <= 1'b0;
    repeat (16) @(negedge core_clk_i);
    check(work_reg_o, 8'h00);
    check(bank_select_reg_o, 8'h00);
    check(dm_wr_o, 1'b0);
    check(dm_rd_o, 1'b0);
    check(fetch_o, 1'b1);
    nrst_i <= 1'b1;
    repeat (4) @(negedge core_clk_i);
    $display("test reset done");
  endtask

  // final verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    error_cnt++;
    complete_run();
  end

  // main sequence
  initial
  begin
    nrst_i = 1'b0;
    junk = 1'b0;
    foreach (mem[i])
      mem[i] = 8'h00;
    @(negedge core_clk_i);
    t_reset();
    t_bank();
    t_work();
    t_copy(12'h000, 12'hFFF, 8'h33);
    t_copy(12'hFFF, 12'h000, 8'hC6);
    t_copy(12'hF80, 12'h200, 8'h3C);
    t_copy(12'h300, 12'hF80, 8'hC5);
    t_bad_dst();
    t_reset();
    complete_run();
  end
endmodule
